// ### pds_pkg.sv
/*
 * constants, field layout and state type for the position deviation and
 * status logic.
 * assumes one 40 MHz clock, a word-wide register port with byte addresses
 * and terminal inputs that are already synchronous to that clock.
 */
//
// Contract
// [RQ1] a mapped, active clear input forces the deviation counter to zero
// [RQ2] while the counter is held clear, position holding is released
// [RQ3] a travel-limit stop keeps the accumulated deviation
// [RQ4] inhibit level blocks command pulses from counting; released, counting resumes
// [RQ5] inhibit only acts when code 0x0D sits in an input slot
// [RQ6] approach output on while deviation inside approach threshold, off outside
// [RQ7] approach output unassigned by default, mapped by output slot code
// [RQ8] done output (code 0x02) on inside completion range, off outside
// [RQ9] completion range takes 0 to 1073741824, default 7
// [RQ10] timing select 0: done depends only on deviation below range
// [RQ11] timing select 1: done also needs filtered command zero
// [RQ12] timing select 2: done also needs raw command input zero
// [RQ13] factory default puts done code 0x02 in the second output slot
// [RQ14] clear trigger: high level, rising edge, low level, falling edge; default 0
// [RQ15] clear action: servo off or fault, input only, or fault; default 0
// [RQ16] deviation is a signed accumulator compared by absolute value
`default_nettype none

package pds_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int N_IN = 9;
   localparam int N_OUT = 4;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_APPR = 8'h04;
   localparam logic [7:0] A_RANGE = 8'h08;
   localparam logic [7:0] A_DEV = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_MASK = 8'h14;
   localparam logic [7:0] A_IN0 = 8'h20;
   localparam logic [7:0] A_OUT0 = 8'h48;
   localparam logic [7:0] A_STEP = 8'h04;

   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   localparam int F_TIM = 0;
   localparam int F_TRG = 2;
   localparam int F_ACT = 4;
   localparam logic [5:0] CTRL_RST = 6'h00;

   // ------------------------------------------------------------
   // function codes, reset values, encodings
   // ------------------------------------------------------------
   localparam logic [7:0] FN_NONE = 8'h00;
   localparam logic [7:0] FN_DONE = 8'h02;
   localparam logic [7:0] FN_APPR = 8'h09;
   localparam logic [7:0] FN_INH = 8'h0D;
   localparam logic [7:0] FN_CLR = 8'h11;
   localparam int DONE_SLOT = 1;
   localparam logic [30:0] RANGE_MAX = 31'h4000_0000;
   localparam logic [30:0] RANGE_RST = 31'h0000_0007;
   localparam logic [30:0] APPR_RST = 31'h0000_0064;

   localparam logic [1:0] TIM_DEV = 2'h0;
   localparam logic [1:0] TIM_FILT = 2'h1;
   localparam logic [1:0] TIM_RAW = 2'h2;
   localparam logic [1:0] TRG_HIGH = 2'h0;
   localparam logic [1:0] TRG_RISE = 2'h1;
   localparam logic [1:0] TRG_LOW = 2'h2;
   localparam logic [1:0] TRG_FALL = 2'h3;
   localparam logic [1:0] ACT_OFF_FLT = 2'h0;
   localparam logic [1:0] ACT_INPUT = 2'h1;
   localparam logic [1:0] ACT_FLT = 2'h2;

   // status bits: done rise, approach rise, deviation cleared
   localparam int S_DONE = 0;
   localparam int S_APPR = 1;
   localparam int S_CLR = 2;

   typedef struct packed {
      logic [5:0] ctrl;
      logic [30:0] appr;
      logic [30:0] rng;
      logic signed [31:0] dev;
      logic [2:0] stat;
      logic [2:0] mask;
      logic [N_IN-1:0][7:0] ina;
      logic [N_OUT-1:0][7:0] outa;
      logic clr_prev;
      logic appr_o;
      logic done_o;
      logic lock;
      logic irq;
      logic [N_OUT-1:0] dout;
      logic [31:0] rdata;
   } pds_state_t;

endpackage : pds_pkg

`default_nettype wire

// ### pds_core.sv
/*
 * deviation counter, clear and inhibit handling, approach and done
 * outputs, terminal mapping, register port and interrupt.
 * assumes single-cycle step pulses from the command and feedback sides
 * and inputs synchronous to mclk.
 */
`default_nettype none

module pds_core (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wstrobe,
   input wire logic rstrobe,
   output logic [31:0] rdata,
   // motion side
   input wire logic cmd_step,
   input wire logic cmd_dir,
   input wire logic fb_step,
   input wire logic fb_dir,
   input wire logic cmd_filt_zero,
   input wire logic cmd_in_zero,
   input wire logic servo_on,
   input wire logic fault,
   // terminals
   input wire logic [pds_pkg::N_IN-1:0] din,
   output logic [pds_pkg::N_OUT-1:0] dout,
   // status
   output logic approach_out,
   output logic position_done_out,
   output logic servo_lock_out,
   output logic irq
);
   import pds_pkg::*;

   pds_state_t s_reg;
   pds_state_t s_next;
   logic [N_IN-1:0] clr_hit;
   logic [N_IN-1:0] inh_hit;
   logic clr_lvl;
   logic clr_mapped;
   logic inhibit;
   logic clr_cond;
   logic clearing;
   logic cmd_ok;
   logic [31:0] abs_dev;
   logic in_appr;
   logic in_rng;
   logic done_c;

   // ------------------------------------------------------------
   // terminal decode
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < N_IN; gi++) begin : g_in
         assign clr_hit[gi] = s_reg.ina[gi] == FN_CLR;
         assign inh_hit[gi] = s_reg.ina[gi] == FN_INH;
      end
   endgenerate

   assign clr_mapped = |clr_hit;
   assign clr_lvl = |(clr_hit & din);
   assign inhibit = |(inh_hit & din); // RQ5

   always_comb begin
      clr_cond = 1'b0;
      unique case (s_reg.ctrl[F_TRG+:2]) // RQ14
         TRG_HIGH: clr_cond = clr_lvl;
         TRG_RISE: clr_cond = clr_lvl & ~s_reg.clr_prev;
         TRG_LOW: clr_cond = ~clr_lvl;
         TRG_FALL: clr_cond = ~clr_lvl & s_reg.clr_prev;
      endcase
      clr_cond = clr_cond & clr_mapped; // RQ1
      clearing = clr_cond;
      unique case (s_reg.ctrl[F_ACT+:2]) // RQ15
         ACT_OFF_FLT: clearing = clr_cond | ~servo_on | fault;
         ACT_INPUT: clearing = clr_cond;
         ACT_FLT: clearing = clr_cond | fault;
         default: clearing = clr_cond;
      endcase
   end

   assign cmd_ok = cmd_step & ~inhibit; // RQ4
   assign abs_dev = s_reg.dev[31] ? 32'(-s_reg.dev) : 32'(s_reg.dev); // RQ16
   assign in_appr = abs_dev < {1'b0, s_reg.appr}; // RQ6
   assign in_rng = abs_dev < {1'b0, s_reg.rng};

   always_comb begin
      unique case (s_reg.ctrl[F_TIM+:2])
         TIM_DEV: done_c = in_rng; // RQ10
         TIM_FILT: done_c = in_rng & cmd_filt_zero; // RQ11
         TIM_RAW: done_c = in_rng & cmd_in_zero; // RQ12
         default: done_c = in_rng;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [2:0] ev;
      logic [31:0] rd;
      s_next = s_reg;
      ev = 3'h0;
      rd = 32'h0000_0000;
      s_next.clr_prev = clr_lvl;
      // no travel-limit term here: a limit stop leaves the count alone
      if (cmd_ok) begin // RQ3
         s_next.dev = cmd_dir ? s_reg.dev - 32'sh1 : s_reg.dev + 32'sh1; // RQ16
      end
      if (fb_step) begin
         s_next.dev = fb_dir ? s_next.dev + 32'sh1 : s_next.dev - 32'sh1;
      end
      if (clearing) begin
         s_next.dev = 32'sh0; // RQ1
      end
      s_next.lock = ~clearing; // RQ2
      s_next.appr_o = in_appr; // RQ6
      s_next.done_o = done_c; // RQ8
      ev[S_DONE] = done_c & ~s_reg.done_o;
      ev[S_APPR] = in_appr & ~s_reg.appr_o;
      ev[S_CLR] = clearing;
      for (int j = 0; j < N_OUT; j++) begin
         s_next.dout[j] = (s_reg.outa[j] == FN_APPR & in_appr)
            | (s_reg.outa[j] == FN_DONE & done_c); // RQ7 RQ8
      end
      if (wstrobe) begin
         unique case (addr)
            A_CTRL: s_next.ctrl = wdata[5:0];
            A_APPR: s_next.appr = wdata[30:0];
            A_RANGE: s_next.rng = (wdata > {1'b0, RANGE_MAX}) ? RANGE_MAX : wdata[30:0]; // RQ9
            A_MASK: s_next.mask = wdata[2:0];
            default: ;
         endcase
         for (int i = 0; i < N_IN; i++) begin
            if (addr == A_IN0 + 8'(i * 4)) begin
               s_next.ina[i] = wdata[7:0];
            end
         end
         for (int j = 0; j < N_OUT; j++) begin
            if (addr == A_OUT0 + 8'(j * 4)) begin
               s_next.outa[j] = wdata[7:0];
            end
         end
      end
      if (rstrobe) begin
         unique case (addr)
            A_CTRL: rd = {26'h0, s_reg.ctrl};
            A_APPR: rd = {1'b0, s_reg.appr};
            A_RANGE: rd = {1'b0, s_reg.rng};
            A_DEV: rd = s_reg.dev;
            A_STAT: rd = {29'h0, s_reg.stat};
            A_MASK: rd = {29'h0, s_reg.mask};
            default: ;
         endcase
         for (int i = 0; i < N_IN; i++) begin
            if (addr == A_IN0 + 8'(i * 4)) begin
               rd = {24'h0, s_reg.ina[i]};
            end
         end
         for (int j = 0; j < N_OUT; j++) begin
            if (addr == A_OUT0 + 8'(j * 4)) begin
               rd = {24'h0, s_reg.outa[j]};
            end
         end
      end
      s_next.rdata = rd;
      // a new event in the read cycle survives the clear-on-read
      if (rstrobe && addr == A_STAT) begin
         s_next.stat = ev;
      end else begin
         s_next.stat = s_reg.stat | ev;
      end
      s_next.irq = |(s_next.stat & s_next.mask);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
         s_reg.ctrl <= CTRL_RST;
         s_reg.appr <= APPR_RST;
         s_reg.rng <= RANGE_RST; // RQ9
         s_reg.outa[DONE_SLOT] <= FN_DONE; // RQ13
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata = s_reg.rdata;
   assign dout = s_reg.dout;
   assign approach_out = s_reg.appr_o;
   assign position_done_out = s_reg.done_o;
   assign servo_lock_out = s_reg.lock;
   assign irq = s_reg.irq;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_clear_zero: assert property (clearing |=> s_reg.dev == 32'sh0) // RQ1
      else $error("deviation not zero after clear");
   a_lock_release: assert property (clearing |=> !servo_lock_out) // RQ2
      else $error("lock held while clearing");
   a_idle_keep: assert property (!clearing && !cmd_ok && !fb_step |=> $stable(s_reg.dev)) // RQ3
      else $error("deviation changed without motion");
   a_inhibit_hold: assert property (inhibit && cmd_step && !fb_step && !clearing |=> $stable(s_reg.dev)) // RQ4
      else $error("inhibited pulse counted");
   a_count_up: assert property (cmd_ok && !cmd_dir && !fb_step && !clearing
      |=> s_reg.dev == $past(s_reg.dev) + 32'sh1) // RQ16
      else $error("command pulse not counted");
   a_inhibit_map: assert property (inh_hit == '0 |-> !inhibit) // RQ5
      else $error("inhibit active while unmapped");
   // the release edge still runs the reset branch, so start one-cycle checks after it
   a_approach_out: assert property (nrst |=> approach_out == $past(in_appr)) // RQ6
      else $error("approach output wrong");
   a_done_base: assert property (nrst && s_reg.ctrl[F_TIM+:2] == TIM_DEV // RQ10
      |=> position_done_out == $past(in_rng))
      else $error("done output wrong");
   a_done_filt: assert property (s_reg.ctrl[F_TIM+:2] == TIM_FILT && !cmd_filt_zero |=> !position_done_out) // RQ11
      else $error("done without filtered command zero");
   a_done_raw: assert property (s_reg.ctrl[F_TIM+:2] == TIM_RAW && !cmd_in_zero |=> !position_done_out) // RQ12
      else $error("done without command input zero");
   a_done_pin: assert property (s_reg.outa[DONE_SLOT] == FN_DONE ##1 1'b1
      |-> dout[DONE_SLOT] == position_done_out) // RQ8
      else $error("done terminal differs");

   c_clear: cover property (clr_cond ##1 s_reg.dev == 32'sh0);
   c_inhibit: cover property (inhibit && cmd_step);
   c_done_rise: cover property (!position_done_out ##1 position_done_out);
   c_irq: cover property (irq ##1 rstrobe && addr == A_STAT);

endmodule : pds_core

`default_nettype wire

// ### pds_ctl_model.sv
/*
 * upper motion controller model: issues command step pulses.
 * assumes the bench calls send() from one process at a time.
 */
`default_nettype none

module pds_ctl_model (
   // clock
   input wire logic mclk,
   // pulse train
   output logic cmd_step,
   output logic cmd_dir
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_step = 1'b0;
      cmd_dir = 1'b0;
   end

   // gap adds idle cycles, so one model serves a fast and a slow controller
   task automatic send(input int n, input logic dir, input int gap);
      repeat (n) begin
         @(posedge mclk);
         cmd_step <= 1'b1;
         cmd_dir <= dir;
         @(posedge mclk);
         cmd_step <= 1'b0;
         repeat (gap) @(posedge mclk);
      end
   endtask : send

endmodule : pds_ctl_model

`default_nettype wire

// ### position_deviation_status_tb.sv
/*
 * self-checking bench for pds_core: register port, counting, clear,
 * inhibit, approach and done outputs, interrupt.
 * assumes pds_pkg and the controller model pds_ctl_model.
 */
`default_nettype none

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end

module position_deviation_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pds_pkg::*;

   localparam logic [31:0] C_IN = 32'(ACT_INPUT) << F_ACT;
   logic mclk, nrst, wstrobe, rstrobe, fb_step, fb_dir, cmd_filt_zero, cmd_in_zero, servo_on, fault;
   logic cmd_step, cmd_dir, approach_out, position_done_out, servo_lock_out, irq, rd_seen;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [N_IN-1:0] din;
   logic [N_OUT-1:0] dout;
   logic [63:0] e_rd;
   logic [63:0] exp_q[$];
   int n_errors, check_count, dev, n;

   pds_core pds_core_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wstrobe(wstrobe),
      .rstrobe(rstrobe), .rdata(rdata), .cmd_step(cmd_step), .cmd_dir(cmd_dir), .fb_step(fb_step),
      .fb_dir(fb_dir), .cmd_filt_zero(cmd_filt_zero), .cmd_in_zero(cmd_in_zero), .servo_on(servo_on),
      .fault(fault), .din(din), .dout(dout), .approach_out(approach_out),
      .position_done_out(position_done_out), .servo_lock_out(servo_lock_out), .irq(irq));
   pds_ctl_model pds_ctl_model_i (.mclk(mclk), .cmd_step(cmd_step), .cmd_dir(cmd_dir));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // read data stand only in the cycle after the strobe edge
   always @(posedge mclk) rd_seen <= rstrobe;
   always @(negedge mclk) if (rd_seen === 1'b1) begin
      e_rd = exp_q.pop_front();
      `CHK("rdata", e_rd[31:0], rdata & e_rd[63:32])
   end

   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wstrobe <= 1'b1;
      @(posedge mclk);
      wstrobe <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
      @(posedge mclk);
      addr <= a;
      rstrobe <= 1'b1;
      exp_q.push_back({m, e});
      @(posedge mclk);
      rstrobe <= 1'b0;
   endtask : rd

   task automatic fb(input int k, input logic d);
      repeat (k) begin
         @(posedge mclk);
         fb_step <= 1'b1;
         fb_dir <= d;
         @(posedge mclk);
         fb_step <= 1'b0;
      end
   endtask : fb

   task automatic go(input int k, input logic d, input int e);
      pds_ctl_model_i.send(k, d, $urandom_range(0, 2));
      rd(A_DEV, 32'(e));
   endtask : go

   task automatic settle;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask : settle

   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      $display("Error timeout expected %h seen %h", 1'b1, 1'b0);
      finish_test();
   end

   initial begin
      {nrst, wstrobe, rstrobe, fb_step, fb_dir, cmd_filt_zero, cmd_in_zero, servo_on, fault} = '0;
      addr = 8'h00;
      wdata = 32'h0;
      din = '0;
      n_errors = 0;
      check_count = 0;
      void'($urandom(32'h6CC9));
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rd(A_CTRL, 32'h0);
      rd(A_APPR, 32'h64);
      rd(A_RANGE, 32'h7);
      rd(A_OUT0 + A_STEP, 32'h2);
      rd(A_OUT0, 32'h0);
      rd(8'h18, 32'h0);
      go(3, 1'b0, 0);
      @(negedge mclk);
      `CHK("lock", 1'b0, servo_lock_out)
      @(posedge mclk) servo_on <= 1'b1;
      n = $urandom_range(1, 6);
      go(n, 1'b0, n);
      settle;
      `CHK("done", 1'b1, position_done_out)
      `CHK("done pin", 1'b1, dout[DONE_SLOT])
      go(7 - n, 1'b0, 7);
      settle;
      `CHK("done", 1'b0, position_done_out)
      fb(1, 1'b0);
      rd(A_DEV, 32'h6);
      settle;
      `CHK("done", 1'b1, position_done_out)
      `CHK("irq", 1'b0, irq)
      @(posedge mclk) fault <= 1'b1;
      @(posedge mclk) fault <= 1'b0;
      rd(A_DEV, 32'h0);
      wr(A_CTRL, 32'(ACT_FLT) << F_ACT);
      @(posedge mclk) servo_on <= 1'b0;
      go(3, 1'b1, -3);
      settle;
      `CHK("done", 1'b1, position_done_out)
      @(posedge mclk) fault <= 1'b1;
      @(posedge mclk) fault <= 1'b0;
      rd(A_DEV, 32'h0);
      wr(A_RANGE, 32'h7FFFFFFF);
      rd(A_RANGE, 32'h40000000);
      wr(A_RANGE, 32'h7);
      go(5, 1'b0, 5);
      for (int t = 0; t < 3; t++) begin
         @(posedge mclk);
         cmd_filt_zero <= (t == 2);
         cmd_in_zero <= (t == 1);
         wr(A_CTRL, C_IN | 32'(t));
         settle;
         `CHK("done sel", t == 0, position_done_out)
         @(posedge mclk) {cmd_filt_zero, cmd_in_zero} <= 2'h3;
         settle;
         `CHK("done sel", 1'b1, position_done_out)
      end
      wr(A_CTRL, C_IN);
      wr(A_OUT0, 32'(FN_APPR));
      wr(A_APPR, 32'h4);
      settle;
      `CHK("approach", 1'b0, approach_out)
      rd(A_STAT, 32'h2, 32'h2);
      rd(A_STAT, 32'h0, 32'h2);
      fb(2, 1'b0);
      settle;
      `CHK("approach", 1'b1, approach_out)
      `CHK("approach pin", 1'b1, dout[0])
      rd(A_STAT, 32'h2, 32'h2);
      @(posedge mclk) din[0] <= 1'b1;
      go(2, 1'b0, 5);
      wr(A_IN0, 32'(FN_INH));
      go(4, 1'b0, 5);
      @(posedge mclk) din[0] <= 1'b0;
      go(1, 1'b0, 6);
      dev = 6;
      wr(A_IN0 + A_STEP, 32'(FN_CLR));
      wr(A_MASK, 32'h1 << S_CLR);
      for (int m = 0; m < 4; m++) begin
         wr(A_CTRL, C_IN | (32'(m) << F_TRG));
         @(posedge mclk) din[1] <= (m >= 2);
         dev += 3;
         go(3, 1'b0, dev);
         @(posedge mclk) din[1] <= (m < 2);
         settle;
         rd(A_DEV, 32'h0);
         @(negedge mclk);
         if (m % 2 == 0) `CHK("lock", 1'b0, servo_lock_out)
         `CHK("irq", 1'b1, irq)
         @(posedge mclk) din[1] <= (m >= 2);
         rd(A_STAT, 32'h4, 32'h4);
         settle;
         `CHK("irq", 1'b0, irq)
         dev = 0;
      end
      settle;
      finish_test();
   end

endmodule : position_deviation_status_tb

`default_nettype wire
